// file: src/tpp_regs.svh
`ifndef TPP_REGS_SVH
`define TPP_REGS_SVH
// How it works
// R1 - average output power over integration time above threshold sets error flag
// R2 - peaks above peak threshold are counted; exceeding allowed count sets error flag
// R3 - while error flag is set, power toward amplifier drops without software
// R4 - protection ramps attenuation up to the maximum attenuation index
// R5 - correction goes through attenuation stage while output power is watched continuously
// R6 - software enables protection and programs average and peak thresholds
// R7 - software can read the current error flag
// R8 - slew limiter clamps output change per sample to configured limit
// R9 - limit is full scale shifted right by slew selection; one eighth takes nine steps from zero to full scale
// R10 - output is fed back and subtracted from input to form difference
// R11 - shift picked by slew selection scales the limit that the difference is clamped to
// R12 - selection spans strong limiting to none, where output follows input
// R13 - direct fm option bypasses protection and attenuation control
// R14 - attenuation ramps in programmable steps with programmable waits, 0.05 db per index
// R15 - error flag sticks until software clears it or protection disabled
// R16 - reset clears slew feedback, peak count, accumulator and error flag

`define TPP_A_CTRL      4'h0
`define TPP_A_AVG_THR   4'h1
`define TPP_A_PEAK_THR  4'h2
`define TPP_A_PEAK_MAX  4'h3
`define TPP_A_INT_LEN   4'h4
`define TPP_A_SLEW      4'h5
`define TPP_A_RAMP      4'h6
`define TPP_A_ATTEN     4'h7
`define TPP_A_STATUS    4'h8
`define TPP_A_MASK      4'h9
`define TPP_A_FLAGS     4'ha

`define TPP_C_PROT_EN   0
`define TPP_C_SLEW_EN   1
`define TPP_C_DFM       2
`define TPP_C_ERR_CLR   3

`define TPP_S_ERR       0
`define TPP_S_AVG       1
`define TPP_S_PEAK      2

`define TPP_ATTEN_MAX   10'h3ff
`define TPP_INT_RST     16'h0400
`define TPP_STEP_RST    8'h01
`define TPP_WAIT_RST    8'h04
`endif

// file: src/tpp_pkg.sv
package tpp_pkg;
  typedef enum {TPP_IDLE, TPP_WAIT, TPP_STEP} tpp_ramp_e;
endpackage

// file: src/tpp_top.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`include "tpp_regs.svh"
module tpp_top
  import tpp_pkg::*;
#(
  parameter int SW = 16
) (
  input  wire logic          CLK_SYS,
  input  wire logic          RST,
  input  wire logic [3:0]    ADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [31:0]   RDATA,
  input  wire logic [SW-1:0] IN_I,
  input  wire logic [SW-1:0] IN_Q,
  input  wire logic          IN_VALID,
  output logic      [SW-1:0] OUT_I,
  output logic      [SW-1:0] OUT_Q,
  output logic               OUT_VALID,
  output logic      [9:0]    ATTEN_IDX,
  output logic               PA_ERR,
  output logic               IRQ
);
  localparam int PW = 2 * SW;
  localparam int AW = PW + 16;

  function automatic logic [SW-1:0] slew_step(input logic [SW-1:0] x, input logic [SW-1:0] y,
                                              input logic [3:0] sel);
    logic signed [SW:0] d;
    logic signed [SW:0] lim;
    d = $signed({x[SW-1], x}) - $signed({y[SW-1], y}); // R10
    lim = $signed({1'b0, {SW{1'b1}}} >> 1) >>> sel;   // R11
    if (sel == 4'hf || lim == '0)
      lim = $signed({1'b0, {SW{1'b1}}});             // R12
    if (d > lim)
      d = lim;                                       // R8
    else if (d < -lim)
      d = -lim;
    slew_step = y + d[SW-1:0];
  endfunction

  function automatic logic [PW-1:0] pwr(input logic [SW-1:0] a, input logic [SW-1:0] b);
    pwr = PW'($signed(a) * $signed(a)) + PW'($signed(b) * $signed(b));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]   ctrl_r, ctrl_nxt, avg_thr_r, avg_thr_nxt, pk_thr_r, pk_thr_nxt;
  logic [15:0]   pk_max_r, pk_max_nxt, int_len_r, int_len_nxt;
  logic [3:0]    slew_r, slew_nxt;
  logic [7:0]    step_r, step_nxt, wait_r, wait_nxt;
  logic [9:0]    tgt_r, tgt_nxt;
  logic [2:0]    sts_r, sts_nxt, mask_r, mask_nxt;
  logic [31:0]   rdata_nxt;
  logic          err_set, avg_ev, pk_ev;

  always_comb begin
    ctrl_nxt    = ctrl_r;
    avg_thr_nxt = avg_thr_r;
    pk_thr_nxt  = pk_thr_r;
    pk_max_nxt  = pk_max_r;
    int_len_nxt = int_len_r;
    slew_nxt    = slew_r;
    step_nxt    = step_r;
    wait_nxt    = wait_r;
    tgt_nxt     = tgt_r;
    mask_nxt    = mask_r;
    sts_nxt     = sts_r;
    rdata_nxt   = '0;
    ctrl_nxt[`TPP_C_ERR_CLR] = 1'b0;
    if (WR) begin
      case (ADDR)
        `TPP_A_CTRL:     ctrl_nxt = {28'h0000000, WDATA[3:0]}; // R6
        `TPP_A_AVG_THR:  avg_thr_nxt = WDATA;                  // R6
        `TPP_A_PEAK_THR: pk_thr_nxt = WDATA;                   // R6
        `TPP_A_PEAK_MAX: pk_max_nxt = WDATA[15:0];
        `TPP_A_INT_LEN:  int_len_nxt = WDATA[15:0];
        `TPP_A_SLEW:     slew_nxt = WDATA[3:0];
        `TPP_A_RAMP: begin
          step_nxt = WDATA[7:0];                               // R14
          wait_nxt = WDATA[15:8];
        end
        `TPP_A_ATTEN:    tgt_nxt = WDATA[9:0];
        `TPP_A_STATUS:   sts_nxt = sts_r & ~WDATA[2:0];
        `TPP_A_MASK:     mask_nxt = WDATA[2:0];
        default: ;
      endcase
    end
    sts_nxt = sts_nxt | {pk_ev, avg_ev, err_set};              // set wins over clear
    if (RD) begin
      case (ADDR)
        `TPP_A_CTRL:     rdata_nxt = ctrl_r;
        `TPP_A_AVG_THR:  rdata_nxt = avg_thr_r;
        `TPP_A_PEAK_THR: rdata_nxt = pk_thr_r;
        `TPP_A_PEAK_MAX: rdata_nxt = {16'h0000, pk_max_r};
        `TPP_A_INT_LEN:  rdata_nxt = {16'h0000, int_len_r};
        `TPP_A_SLEW:     rdata_nxt = {28'h0000000, slew_r};
        `TPP_A_RAMP:     rdata_nxt = {16'h0000, wait_r, step_r};
        `TPP_A_ATTEN:    rdata_nxt = {6'h00, ATTEN_IDX, 6'h00, tgt_r};
        `TPP_A_STATUS:   rdata_nxt = {29'h0000000, sts_r};
        `TPP_A_MASK:     rdata_nxt = {29'h0000000, mask_r};
        `TPP_A_FLAGS:    rdata_nxt = {31'h00000000, PA_ERR};   // R7
        default:         rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_r    <= '0;
      avg_thr_r <= '1;
      pk_thr_r  <= '1;
      pk_max_r  <= '1;
      int_len_r <= `TPP_INT_RST;
      slew_r    <= 4'hf;
      step_r    <= `TPP_STEP_RST;
      wait_r    <= `TPP_WAIT_RST;
      tgt_r     <= '0;
      sts_r     <= '0;
      mask_r    <= '0;
      RDATA     <= '0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      avg_thr_r <= avg_thr_nxt;
      pk_thr_r  <= pk_thr_nxt;
      pk_max_r  <= pk_max_nxt;
      int_len_r <= int_len_nxt;
      slew_r    <= slew_nxt;
      step_r    <= step_nxt;
      wait_r    <= wait_nxt;
      tgt_r     <= tgt_nxt;
      sts_r     <= sts_nxt;
      mask_r    <= mask_nxt;
      RDATA     <= rdata_nxt;
    end
  end

  assign IRQ = |(sts_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // power monitor
  logic          prot_on;
  logic [PW-1:0] p_now;
  logic [AW-1:0] acc_r, acc_nxt;
  logic [15:0]   icnt_r, icnt_nxt, pcnt_r, pcnt_nxt;
  logic          err_r, err_nxt;

  assign prot_on = ctrl_r[`TPP_C_PROT_EN] & ~ctrl_r[`TPP_C_DFM]; // R13
  assign p_now   = pwr(OUT_I, OUT_Q);                           // R5

  always_comb begin
    acc_nxt  = acc_r;
    icnt_nxt = icnt_r;
    pcnt_nxt = pcnt_r;
    avg_ev   = 1'b0;
    pk_ev    = 1'b0;
    if (!prot_on) begin
      acc_nxt  = '0;
      icnt_nxt = '0;
      pcnt_nxt = '0;
    end else if (OUT_VALID) begin
      acc_nxt  = acc_r + AW'(p_now);                            // R1
      icnt_nxt = icnt_r + 16'h0001;
      if (icnt_r + 16'h0001 >= int_len_r) begin
        avg_ev   = (acc_nxt >> 16) > AW'(avg_thr_r) * AW'(int_len_r) >> 16
                   || acc_nxt[AW-1:0] > AW'(avg_thr_r) * AW'(int_len_r); // R1
        acc_nxt  = '0;
        icnt_nxt = '0;
      end
      if (p_now > PW'(pk_thr_r)) begin
        pcnt_nxt = (pcnt_r == '1) ? pcnt_r : pcnt_r + 16'h0001; // R2
        pk_ev    = pcnt_nxt > pk_max_r;                         // R2
      end
    end
  end

  always_comb begin
    err_set = avg_ev | pk_ev;
    err_nxt = err_r;
    if (!prot_on || ctrl_r[`TPP_C_ERR_CLR])
      err_nxt = 1'b0;                                           // R15
    if (prot_on && err_set)
      err_nxt = 1'b1;                                           // R15
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      acc_r  <= '0;                                             // R16
      icnt_r <= '0;
      pcnt_r <= '0;                                             // R16
      err_r  <= 1'b0;                                           // R16
    end else begin
      acc_r  <= acc_nxt;
      icnt_r <= icnt_nxt;
      pcnt_r <= pcnt_nxt;
      err_r  <= err_nxt;
    end
  end

  assign PA_ERR = err_r;

  ////////////////////////////////////////////////////////////////////////////
  // attenuation ramp, 0.05 db per index
  tpp_ramp_e   st_r, st_nxt;
  logic [7:0]  wc_r, wc_nxt;
  logic [9:0]  att_nxt, goal;

  assign goal = ctrl_r[`TPP_C_DFM] ? 10'h000 :
                (err_r ? `TPP_ATTEN_MAX : tgt_r);               // R3 R4 R13

  always_comb begin
    st_nxt  = st_r;
    wc_nxt  = wc_r;
    att_nxt = ATTEN_IDX;
    case (st_r)
      TPP_IDLE:
        if (goal != ATTEN_IDX) begin
          st_nxt = TPP_WAIT;
          wc_nxt = wait_r;
        end
      TPP_WAIT:
        if (wc_r == '0)
          st_nxt = TPP_STEP;
        else
          wc_nxt = wc_r - 8'h01;                                // R14
      TPP_STEP: begin
        if (goal > ATTEN_IDX)
          att_nxt = (goal - ATTEN_IDX > 10'(step_r)) ? ATTEN_IDX + 10'(step_r) : goal; // R4 R14
        else if (goal < ATTEN_IDX)
          att_nxt = (ATTEN_IDX - goal > 10'(step_r)) ? ATTEN_IDX - 10'(step_r) : goal;
        st_nxt = TPP_IDLE;
      end
      default: st_nxt = TPP_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_r      <= TPP_IDLE;
      wc_r      <= '0;
      ATTEN_IDX <= '0;
    end else begin
      st_r      <= st_nxt;
      wc_r      <= wc_nxt;
      ATTEN_IDX <= att_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slew limiter
  logic [SW-1:0] oi_nxt, oq_nxt;
  logic [3:0]    sel;

  assign sel = (ctrl_r[`TPP_C_SLEW_EN] && !ctrl_r[`TPP_C_DFM]) ? slew_r : 4'hf;

  always_comb begin
    oi_nxt = OUT_I;
    oq_nxt = OUT_Q;
    if (IN_VALID) begin
      oi_nxt = slew_step(IN_I, OUT_I, sel);                     // R8 R9
      oq_nxt = slew_step(IN_Q, OUT_Q, sel);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      OUT_I     <= '0;                                          // R16
      OUT_Q     <= '0;
      OUT_VALID <= 1'b0;
    end else begin
      OUT_I     <= oi_nxt;
      OUT_Q     <= oq_nxt;
      OUT_VALID <= IN_VALID;
    end
  end
endmodule

// file: tb/tpp_props.sv
module tpp_props (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        IN_VALID,
  input wire logic        OUT_VALID,
  input wire logic [9:0]  ATTEN_IDX,
  input wire logic        PA_ERR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_rst; $fell(RST) |-> ATTEN_IDX == 10'h0 && !PA_ERR && !OUT_VALID; endproperty
  property p_vld; OUT_VALID == $past(IN_VALID); endproperty
  property p_rd0; !$past(RD) |-> RDATA == 32'h0; endproperty
  property p_flag; RD && ADDR == 4'ha |=> RDATA[31:1] == 31'h0; endproperty
  // a control write takes effect one cycle later, so the cycle after it is excused too
  property p_sticky;
    PA_ERR && !(WR && ADDR == 4'h0) && !$past(WR && ADDR == 4'h0) |=> PA_ERR;
  endproperty
  property p_clr; WR && ADDR == 4'h0 && !WDATA[0] |=> ##1 !PA_ERR; endproperty
  property p_up; PA_ERR |=> ATTEN_IDX >= $past(ATTEN_IDX); endproperty
  property p_idle; $changed(ATTEN_IDX) |=> $stable(ATTEN_IDX); endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  a_vld: assert property (p_vld) else $error("output valid not one cycle late");
  a_rd0: assert property (p_rd0) else $error("read data outside read slot");
  a_flag: assert property (p_flag) else $error("flag word upper bits set");
  a_sticky: assert property (p_sticky) else $error("error flag dropped");
  a_clr: assert property (p_clr) else $error("error flag kept with protection off");
  a_up: assert property (p_up) else $error("attenuation fell during error");
  a_idle: assert property (p_idle) else $error("attenuation steps back to back");
  c_err: cover property ($rose(PA_ERR));
  c_max: cover property (ATTEN_IDX == 10'h3ff);
  c_clr: cover property ($fell(PA_ERR));
endmodule
bind tpp_top tpp_props u_props (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IN_VALID, .OUT_VALID,
  .ATTEN_IDX, .PA_ERR);

// file: tb/tpp_src.sv
module tpp_src (
  input wire logic        clk,
  input wire logic [15:0] ni,
  input wire logic [15:0] nq,
  input wire logic        nv,
  output logic     [15:0] i,
  output logic     [15:0] q,
  output logic            v
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle samples show the inverse, never a stale copy
  always_ff @(posedge clk) begin
    v <= nv;
    i <= nv ? ni : ~ni;
    q <= nv ? nq : ~nq;
  end
endmodule

// file: tb/test_tx_pa_protection.sv
module test_tx_pa_protection import tpp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_SYS = 0, RST = 1, WR = 0, RD = 0, nv = 0, rd_d = 0;
  logic [3:0]  ADDR = 0;
  logic [31:0] WDATA = 0;
  logic [15:0] ni = 0, nq = 0;
  wire  [15:0] IN_I, IN_Q, OUT_I, OUT_Q;
  wire         IN_VALID, OUT_VALID, PA_ERR, IRQ;
  wire  [9:0]  ATTEN_IDX;
  wire  [31:0] RDATA;
  logic [31:0] rq[$], oq[$];
  int          err_total = 0, checks_done = 0, lim = 0, si = 0, sq = 0;
  tpp_src src (.clk(CLK_SYS), .ni, .nq, .nv, .i(IN_I), .q(IN_Q), .v(IN_VALID));
  tpp_top #(.SW(16)) dut (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IN_I, .IN_Q, .IN_VALID,
    .OUT_I, .OUT_Q, .OUT_VALID, .ATTEN_IDX, .PA_ERR, .IRQ);
  initial forever #2.5 CLK_SYS = ~CLK_SYS;
  //////////////////////////////////////
  task chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1;
    @(posedge CLK_SYS);
    WR <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1;
    rq.push_back(e);
    @(posedge CLK_SYS);
    RD <= 0;
  endtask
  // reference limiter: clamp the step toward the input
  function int lmt(int s, int x);
    int d;
    d = x - s;
    if (lim > 0 && d > lim) d = lim;
    if (lim > 0 && d < -lim) d = -lim;
    return s + d;
  endfunction
  task snd(input logic signed [15:0] i, q);
    @(posedge CLK_SYS);
    ni <= i;
    nq <= q;
    nv <= 1;
    si = lmt(si, i);
    sq = lmt(sq, q);
    oq.push_back({si[15:0], sq[15:0]});
  endtask
  task quiet;
    @(posedge CLK_SYS);
    nv <= 0;
  endtask
  task wait_att(input logic [9:0] v);
    for (int k = 0; k < 300 && ATTEN_IDX !== v; k++) @(posedge CLK_SYS);
    chk(ATTEN_IDX, v);
  endtask
  task wait_err(input logic v);
    for (int k = 0; k < 60 && PA_ERR !== v; k++) @(posedge CLK_SYS);
    chk(PA_ERR, v);
  endtask
  task prot(input logic [31:0] at, pt, st);
    wr(4, 4);
    wr(1, at);
    wr(2, pt);
    wr(3, 1);
    wr(9, 1);
    wr(6, 32'hff);
    wr(0, 1);
    repeat (6) snd(16'sd1000, 16'sd0);
    quiet;
    wait_err(1);
    rd(4'ha, 1);
    rd(4'h8, st);
    wait_att(10'h3ff);
    chk(IRQ, 1);
    wr(9, 0);
    repeat (2) @(posedge CLK_SYS);
    chk(IRQ, 0);
    wr(0, 32'h9);
    wait_err(0);
    wr(0, 0);
    wait_err(0);
    wr(8, 7);
    rd(8, 0);
    wait_att(10'h20);
  endtask
  //////////////////////////////////////
  always @(posedge CLK_SYS) begin
    if (rd_d) chk(RDATA, rq.pop_front());
    if (OUT_VALID === 1'b1) chk({OUT_I, OUT_Q}, oq.pop_front());
    rd_d <= RD;
  end
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    err_total++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h8d3e8a62));
    repeat (3) @(posedge CLK_SYS);
    RST <= 0;
    rd(4'h5, 32'hf);
    rd(4'h4, 32'h400);
    rd(4'h6, 32'h401);
    rd(4'ha, 0);
    wr(4'hb, 32'h55);
    rd(4'hb, 0);
    wr(7, 32'h20);
    wait_att(10'h20);
    rd(4'h7, 32'h0020_0020);
    prot(32'h00ff_ffff, 32'd100, 5);
    prot(32'd100, 32'h00ff_ffff, 3);
    repeat (16) snd(16'($urandom), 16'($urandom));
    quiet;
    wr(0, 2);
    wr(5, 3);
    lim = 4095;
    repeat (10) snd(16'sh7fff, 16'sh8001);
    quiet;
    wr(0, 6);
    lim = 0;
    wait_att(0);
    repeat (4) snd(16'sh8001, 16'sh7fff);
    quiet;
    repeat (5) @(posedge CLK_SYS);
    chk(rq.size(), 0);
    chk(oq.size(), 0);
    finish_test;
  end
endmodule
